/* File: hdl/nvm_consts.svh */
// Register indices, bit positions and timing constants of the nonvolatile access block
// What this block does
// - Program-memory select clear targets data EEPROM; set targets flash program memory
// - Config select set routes operations to configuration registers, overriding program-memory select
// - Write enable bit is cleared at power-up
// - No flash or EEPROM write cycle starts while write enable is zero
// - Write error flag sets with write start, clears when timed write completes
// - Master-clear or watchdog reset during a write leaves the error flag set
// - Program-memory and config select survive a write error for tracing
// - Software only sets write start; hardware clears it at completion
// - Completion sets done flag in peripheral flags two; software clears it
// - Read start refused while program-memory select or config select is one
// - EEPROM read takes one cycle; read start self-clears, data ready next cycle
// - Data register holds last read until next read or software write
// - Unlock port has no storage, reads zero, only feeds unlock sequence
// - EEPROM address is 10 bits: 8 low bits plus 2 high bits
// - Each EEPROM byte write erases the location then writes, timer-controlled
// - Row erase bit makes next flash write start erase the pointed block; self-clears
// - Flash program or erase stalls instruction execution until it finishes
// - Write starts only after 55h then AAh to unlock port, each time
// - While a write runs, control, address and data writes are ignored
// - Write start cannot be set in the same write that sets write enable
`ifndef NVM_CONSTS_SVH
`define NVM_CONSTS_SVH
`define IDX_TBL_UPPER   4'h0
`define IDX_TBL_HIGH    4'h1
`define IDX_TBL_LOW     4'h2
`define IDX_TBL_LATCH   4'h3
`define IDX_UNLOCK      4'h4
`define IDX_CONTROL     4'h5
`define IDX_ADDR_LOW    4'h6
`define IDX_ADDR_HIGH   4'h7
`define IDX_DATA        4'h8
`define IDX_FLAGS_TWO   4'h9
`define IDX_ENABLES_TWO 4'hA
`define IDX_PRIORITY_TWO 4'hB
`define BIT_PGM_SEL     7
`define BIT_CFG_SEL     6
`define BIT_ROW_ERASE   4
`define BIT_WERR        3
`define BIT_WRITE_ENABLE_BIT        2
`define BIT_WSTART      1
`define BIT_RSTART      0
`define BIT_DONE        4
`define UNLOCK_FIRST    8'h55
`define UNLOCK_SECOND   8'hAA
`define ERASED_BYTE     8'hFF
`define ZERO_BYTE       8'h00
`define EE_DEPTH        1024
`define TIMER_W         20
`define WRITE_TIME_NS   4000000
`define CLK_PERIOD_NS   8
`endif

/* File: hdl/nvm_pkg.sv */
// Types shared by the nonvolatile access block
package nvm_pkg;
  typedef enum logic [1:0] {UNLOCK_IDLE, UNLOCK_GOT_FIRST, UNLOCK_ARMED} unlock_state_t;
  typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_PROGRAM} op_state_t;
  typedef enum logic [1:0] {TARGET_EEPROM, TARGET_FLASH, TARGET_CONFIG} target_t;
endpackage

/* File: hdl/nvm_write_timer.sv */
// Self-timed write duration counter
`include "nvm_consts.svh"
module nvm_write_timer #(
  parameter int unsigned CYCLES = 500000
) (
  input  wire logic sys_clk_in,
  input  wire logic rst_b_in,
  input  wire logic start_in,
  input  wire logic abort_in,
  output logic      done_out
);
  logic [`TIMER_W-1:0] cnt_reg;
  logic                running_reg;

  // Counts down from load; done pulses CYCLES edges after start
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_reg     <= '0;
      running_reg <= 1'b0;
      done_out    <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (abort_in) begin
        running_reg <= 1'b0;
      end else if (start_in) begin
        cnt_reg     <= `TIMER_W'(CYCLES - 1);
        running_reg <= 1'b1;
      end else if (running_reg) begin
        if (cnt_reg == '0) begin
          running_reg <= 1'b0;
          done_out    <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - `TIMER_W'(1);
        end
      end
    end
  end
endmodule // nvm_write_timer

/* File: hdl/nvm_access_control.sv */
// Nonvolatile memory access control: registers, unlock, read and timed write
`include "nvm_consts.svh"
module nvm_access_control
  import nvm_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `WRITE_TIME_NS / `CLK_PERIOD_NS
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        master_clear_reset_in,
  input  wire logic        watchdog_timer_reset_in,
  input  wire logic [3:0]  sfr_sel_in,
  input  wire logic        sfr_wr_in,
  input  wire logic [7:0]  sfr_wdata_in,
  output logic      [7:0]  sfr_rdata_out,
  output logic             cpu_stall_out,
  output logic             nvm_erase_out,
  output logic             nvm_program_out,
  output logic      [1:0]  nvm_target_out,
  output logic      [21:0] nvm_op_addr_out,
  output logic      [7:0]  nvm_op_data_out,
  output logic             nvm_done_flag_out,
  output logic             nvm_done_enable_out,
  output logic             nvm_done_priority_out
);
  // Control register fields
  logic          pgm_sel_reg;
  logic          cfg_sel_reg;
  logic          row_erase_reg;
  logic          werr_reg;
  logic          write_enable_bit_reg;
  logic          wstart_reg;
  logic          rstart_reg;
  // Address, data and table registers
  logic [7:0]    addr_low_reg;
  logic [1:0]    addr_high_reg;
  logic [7:0]    data_reg;
  logic [5:0]    tbl_upper_reg;
  logic [7:0]    tbl_high_reg;
  logic [7:0]    tbl_low_reg;
  logic [7:0]    tbl_latch_reg;
  // Sequencing state
  unlock_state_t unlock_reg;
  unlock_state_t unlock_next;
  op_state_t     op_reg;
  op_state_t     op_next;
  target_t       target_reg;
  target_t       target_next;
  logic [7:0]    rdata_next;
  logic [7:0]    mem [0:`EE_DEPTH-1];

  // Access decode
  wire        wr_ctrl    = sfr_wr_in && (sfr_sel_in == `IDX_CONTROL);
  wire        wr_unlock  = sfr_wr_in && (sfr_sel_in == `IDX_UNLOCK);
  wire        wr_flags   = sfr_wr_in && (sfr_sel_in == `IDX_FLAGS_TWO);
  wire [7:0]  wd         = sfr_wdata_in;
  wire        warm       = master_clear_reset_in || watchdog_timer_reset_in;
  wire        busy       = (op_reg != OP_IDLE);
  wire        ctrl_ok    = wr_ctrl && !busy;
  wire [9:0]  ee_addr    = {addr_high_reg, addr_low_reg};
  wire [21:0] tbl_ptr    = {tbl_upper_reg, tbl_high_reg, tbl_low_reg};
  wire        timer_done;

  // Write start gating: unlock armed, enable already set, not busy
  wire start_req = ctrl_ok && wd[`BIT_WSTART] && !warm;
  wire start_ok  = start_req && write_enable_bit_reg && (unlock_reg == UNLOCK_ARMED);
  wire start_bad = start_req && !start_ok;
  // Reads only of data EEPROM; the written select bits decide
  wire read_ok   = ctrl_ok && wd[`BIT_RSTART] && !wd[`BIT_PGM_SEL] && !wd[`BIT_CFG_SEL];

  // Phase ends; EEPROM erase rolls into its program phase
  wire ee_roll   = timer_done && (op_reg == OP_ERASE) && (target_reg == TARGET_EEPROM);
  wire finish    = timer_done && !ee_roll && busy;
  wire tmr_start = start_ok || ee_roll;

  // Target choice at start time
  wire target_t  new_target = cfg_sel_reg ? TARGET_CONFIG :
                              pgm_sel_reg ? TARGET_FLASH : TARGET_EEPROM;

  // Unlock sequence tracker; any other write breaks it
  always_comb begin
    unlock_next = unlock_reg;
    if (wr_unlock) begin
      if (wd == `UNLOCK_FIRST) begin
        unlock_next = UNLOCK_GOT_FIRST;
      end else if (wd == `UNLOCK_SECOND && unlock_reg == UNLOCK_GOT_FIRST) begin
        unlock_next = UNLOCK_ARMED;
      end else begin
        unlock_next = UNLOCK_IDLE;
      end
    end else if (sfr_wr_in || warm) begin
      unlock_next = UNLOCK_IDLE;
    end
  end

  // Operation sequencer
  always_comb begin
    op_next     = op_reg;
    target_next = target_reg;
    if (warm) begin
      op_next = OP_IDLE;
    end else begin
      case (op_reg)
        OP_IDLE: begin
          if (start_ok) begin
            target_next = new_target;
            if (new_target == TARGET_EEPROM) begin
              op_next = OP_ERASE;
            end else if (new_target == TARGET_FLASH && row_erase_reg) begin
              op_next = OP_ERASE;
            end else begin
              op_next = OP_PROGRAM;
            end
          end
        end
        OP_ERASE: begin
          if (ee_roll) begin
            op_next = OP_PROGRAM;
          end else if (timer_done) begin
            op_next = OP_IDLE;
          end
        end
        OP_PROGRAM: begin
          if (timer_done) begin
            op_next = OP_IDLE;
          end
        end
        default: begin
          op_next = OP_IDLE;
        end
      endcase
    end
  end

  // Register read mux; unlock port reads zero
  always_comb begin
    case (sfr_sel_in)
      `IDX_TBL_UPPER:    rdata_next = {2'h0, tbl_upper_reg};
      `IDX_TBL_HIGH:     rdata_next = tbl_high_reg;
      `IDX_TBL_LOW:      rdata_next = tbl_low_reg;
      `IDX_TBL_LATCH:    rdata_next = tbl_latch_reg;
      `IDX_UNLOCK:       rdata_next = `ZERO_BYTE;
      `IDX_CONTROL:      rdata_next = {pgm_sel_reg, cfg_sel_reg, 1'b0, row_erase_reg,
                                       werr_reg, write_enable_bit_reg, wstart_reg, rstart_reg};
      `IDX_ADDR_LOW:     rdata_next = addr_low_reg;
      `IDX_ADDR_HIGH:    rdata_next = {6'h00, addr_high_reg};
      `IDX_DATA:         rdata_next = data_reg;
      `IDX_FLAGS_TWO:    rdata_next = {3'h0, nvm_done_flag_out, 4'h0};
      `IDX_ENABLES_TWO:  rdata_next = {3'h0, nvm_done_enable_out, 4'h0};
      `IDX_PRIORITY_TWO: rdata_next = {3'h0, nvm_done_priority_out, 4'h0};
      default:           rdata_next = `ZERO_BYTE;
    endcase
  end

  // Write duration timer
  nvm_write_timer #(
    .CYCLES (WRITE_CYCLES)
  ) u_timer (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .start_in   (tmr_start),
    .abort_in   (warm),
    .done_out   (timer_done)
  );

  // Select bits: power-on clear only, warm resets leave them for tracing
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pgm_sel_reg <= 1'b0;
      cfg_sel_reg <= 1'b0;
    end else if (ctrl_ok && !warm) begin
      pgm_sel_reg <= wd[`BIT_PGM_SEL];
      cfg_sel_reg <= wd[`BIT_CFG_SEL];
    end
  end

  // Enable and row erase; warm reset drops them
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      write_enable_bit_reg      <= 1'b0;
      row_erase_reg <= 1'b0;
    end else if (warm) begin
      write_enable_bit_reg      <= 1'b0;
      row_erase_reg <= 1'b0;
    end else if (ctrl_ok) begin
      write_enable_bit_reg      <= wd[`BIT_WRITE_ENABLE_BIT];
      row_erase_reg <= wd[`BIT_ROW_ERASE];
    end else if (finish && op_reg == OP_ERASE) begin
      row_erase_reg <= 1'b0;
    end
  end

  // Error flag: set on any start attempt, cleared by clean completion or loaded by a control write when idle
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      werr_reg <= 1'b0;
    end else if (start_ok || start_bad) begin
      werr_reg <= 1'b1;
    end else if (finish) begin
      werr_reg <= 1'b0;
    end else if (ctrl_ok && !warm) begin
      werr_reg <= wd[`BIT_WERR];
    end
  end

  // Start bits: software sets, hardware clears
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wstart_reg <= 1'b0;
      rstart_reg <= 1'b0;
    end else begin
      if (warm || finish) begin
        wstart_reg <= 1'b0;
      end else if (start_ok) begin
        wstart_reg <= 1'b1;
      end
      rstart_reg <= read_ok && !warm;
    end
  end

  // Address, data and table registers; address and data frozen while busy
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      addr_low_reg  <= '0;
      addr_high_reg <= '0;
      data_reg      <= '0;
      tbl_upper_reg <= '0;
      tbl_high_reg  <= '0;
      tbl_low_reg   <= '0;
      tbl_latch_reg <= '0;
    end else begin
      if (sfr_wr_in && !busy && sfr_sel_in == `IDX_ADDR_LOW)
        addr_low_reg <= wd;
      if (sfr_wr_in && !busy && sfr_sel_in == `IDX_ADDR_HIGH)
        addr_high_reg <= wd[1:0];
      if (rstart_reg)
        data_reg <= mem[ee_addr];
      else if (sfr_wr_in && !busy && sfr_sel_in == `IDX_DATA)
        data_reg <= wd;
      if (sfr_wr_in && sfr_sel_in == `IDX_TBL_UPPER)
        tbl_upper_reg <= wd[5:0];
      if (sfr_wr_in && sfr_sel_in == `IDX_TBL_HIGH)
        tbl_high_reg <= wd;
      if (sfr_wr_in && sfr_sel_in == `IDX_TBL_LOW)
        tbl_low_reg <= wd;
      if (sfr_wr_in && sfr_sel_in == `IDX_TBL_LATCH)
        tbl_latch_reg <= wd;
    end
  end

  // Data EEPROM array: erase to blank, then program the byte
  always_ff @(posedge sys_clk_in) begin
    if (ee_roll)
      mem[ee_addr] <= `ERASED_BYTE;
    else if (finish && target_reg == TARGET_EEPROM)
      mem[ee_addr] <= data_reg;
  end

  // Done flag and its enable and priority; set beats software clear
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      nvm_done_flag_out     <= 1'b0;
      nvm_done_enable_out   <= 1'b0;
      nvm_done_priority_out <= 1'b0;
    end else begin
      if (finish)
        nvm_done_flag_out <= 1'b1;
      else if (wr_flags)
        nvm_done_flag_out <= wd[`BIT_DONE];
      if (sfr_wr_in && sfr_sel_in == `IDX_ENABLES_TWO)
        nvm_done_enable_out <= wd[`BIT_DONE];
      if (sfr_wr_in && sfr_sel_in == `IDX_PRIORITY_TWO)
        nvm_done_priority_out <= wd[`BIT_DONE];
    end
  end

  // State and registered outputs; op address and data captured at start
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      unlock_reg      <= UNLOCK_IDLE;
      op_reg          <= OP_IDLE;
      target_reg      <= TARGET_EEPROM;
      sfr_rdata_out   <= '0;
      cpu_stall_out   <= 1'b0;
      nvm_erase_out   <= 1'b0;
      nvm_program_out <= 1'b0;
      nvm_target_out  <= '0;
      nvm_op_addr_out <= '0;
      nvm_op_data_out <= '0;
    end else begin
      unlock_reg      <= unlock_next;
      op_reg          <= op_next;
      target_reg      <= target_next;
      sfr_rdata_out   <= rdata_next;
      cpu_stall_out   <= (op_next != OP_IDLE) && (target_next != TARGET_EEPROM);
      nvm_erase_out   <= (op_next == OP_ERASE);
      nvm_program_out <= (op_next == OP_PROGRAM);
      nvm_target_out  <= target_next;
      if (start_ok) begin
        nvm_op_addr_out <= (new_target == TARGET_EEPROM) ? {12'h000, ee_addr} : tbl_ptr;
        nvm_op_data_out <= (new_target == TARGET_EEPROM) ? data_reg : tbl_latch_reg;
      end
    end
  end

  // Checks on the control sequencing
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence seq_flash_start;
    start_ok && pgm_sel_reg && !cfg_sel_reg;
  endsequence

  sequence seq_ee_read;
    read_ok ##1 rstart_reg;
  endsequence

  a_read_one_cycle: assert property (seq_ee_read |=> !rstart_reg && data_reg == mem[$past(ee_addr)])
    else $error("read start not cleared or data not loaded");
  a_read_refused: assert property (wr_ctrl && (wd[`BIT_PGM_SEL] || wd[`BIT_CFG_SEL]) |=> !rstart_reg)
    else $error("read started with program or config select set");
  a_start_gating: assert property ($rose(wstart_reg) |-> $past(write_enable_bit_reg) && $past(unlock_reg) == UNLOCK_ARMED)
    else $error("write started without unlock or enable");
  a_error_on_start: assert property ($rose(wstart_reg) |-> werr_reg)
    else $error("error flag not set with write start");
  a_done_completion: assert property (finish |=> !wstart_reg && !werr_reg && nvm_done_flag_out)
    else $error("completion did not clear start and error or set done");
  a_start_sticky: assert property (wstart_reg && !finish && !warm |=> wstart_reg)
    else $error("write start cleared before completion");
  a_busy_locks_regs: assert property (busy && !warm |=> $stable(pgm_sel_reg) && $stable(ee_addr))
    else $error("control or address changed during write");
  a_warm_keeps_err: assert property (warm && busy |=> werr_reg && !busy && $stable(cfg_sel_reg))
    else $error("interrupted write lost its error flag");
  a_flash_stall: assert property (seq_flash_start |=> cpu_stall_out throughout (busy [*2]))
    else $error("flash operation did not stall the processor");
  a_ee_erase_first: assert property (start_ok && !pgm_sel_reg && !cfg_sel_reg |=> nvm_erase_out)
    else $error("EEPROM write did not begin with erase");
  a_same_write_enable: assert property (!write_enable_bit_reg && wr_ctrl |=> !wstart_reg || $past(wstart_reg))
    else $error("write start set together with write enable");
endmodule // nvm_access_control

/* File: verif/testbench.sv */
// Self-checking bench for the nonvolatile access control block
`include "nvm_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Short write time keeps the run brief
  localparam int unsigned WCYC = 8;
  localparam logic [3:0] CTL = `IDX_CONTROL;
  localparam logic [3:0] ULK = `IDX_UNLOCK;
  localparam logic [3:0] FLG = `IDX_FLAGS_TWO;
  localparam logic [3:0] DAT = `IDX_DATA;
  localparam logic [3:0] ALO = `IDX_ADDR_LOW;

  logic        sys_clk_in;
  logic        rst_b_in;
  logic        master_clear_reset_in;
  logic        watchdog_timer_reset_in;
  logic [3:0]  sfr_sel_in;
  logic        sfr_wr_in;
  logic [7:0]  sfr_wdata_in;
  logic [7:0]  sfr_rdata_out;
  logic        cpu_stall_out;
  logic        nvm_erase_out;
  logic        nvm_program_out;
  logic [1:0]  nvm_target_out;
  logic [21:0] nvm_op_addr_out;
  logic [7:0]  nvm_op_data_out;
  logic        nvm_done_flag_out;
  logic        nvm_done_enable_out;
  logic        nvm_done_priority_out;
  int          err_count;
  int          checked;

  nvm_access_control #(.WRITE_CYCLES(WCYC)) i_nvm_access_control (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .master_clear_reset_in(master_clear_reset_in),
    .watchdog_timer_reset_in(watchdog_timer_reset_in), .sfr_sel_in(sfr_sel_in), .sfr_wr_in(sfr_wr_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out), .cpu_stall_out(cpu_stall_out),
    .nvm_erase_out(nvm_erase_out), .nvm_program_out(nvm_program_out), .nvm_target_out(nvm_target_out),
    .nvm_op_addr_out(nvm_op_addr_out), .nvm_op_data_out(nvm_op_data_out),
    .nvm_done_flag_out(nvm_done_flag_out), .nvm_done_enable_out(nvm_done_enable_out),
    .nvm_done_priority_out(nvm_done_priority_out));

  // Free-running system clock, 8 ns
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  task automatic end_of_test;
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // One compare for every kind of value, widened to the op address width
  task automatic chk(input logic [21:0] got, input logic [21:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // Strobe held one cycle; the gap edge keeps writes from colliding
  task automatic wr(input logic [3:0] s, input logic [7:0] d);
    @(posedge sys_clk_in);
    sfr_sel_in   <= s;
    sfr_wdata_in <= d;
    sfr_wr_in    <= 1'b1;
    @(posedge sys_clk_in);
    sfr_wr_in <= 1'b0;
  endtask

  // Read data is registered, so sample one edge after the select lands
  task automatic rchk(input logic [3:0] s, input logic [7:0] exp);
    @(posedge sys_clk_in);
    sfr_sel_in <= s;
    @(posedge sys_clk_in);
    #1;
    chk({14'h0, sfr_rdata_out}, {14'h0, exp}, "register read");
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    chk({21'h0, got}, {21'h0, exp}, what);
  endtask

  // Enable first, then the unlock pair, then the start in its own write
  task automatic start_wr(input logic [7:0] ctl);
    wr(CTL, ctl & 8'hFD);
    wr(ULK, `UNLOCK_FIRST);
    wr(ULK, `UNLOCK_SECOND);
    wr(CTL, ctl | 8'h02);
    #1;
  endtask

  // Bounded poll for the completion flag
  task automatic wait_done;
    int n;
    for (n = 0; n < 100 && nvm_done_flag_out !== 1'b1; n++) begin
      @(posedge sys_clk_in);
      #1;
    end
    if (nvm_done_flag_out !== 1'b1) begin
      err_count++;
      $display("Error at %0t: completion timeout", $time);
      end_of_test;
    end
  endtask

  task automatic t_reset_values;
    rchk(CTL, 8'h00);
    rchk(FLG, 8'h00);
    wr(ULK, 8'h55);
    rchk(ULK, 8'h00);
    rchk(4'hC, 8'h00);
    wr(`IDX_ENABLES_TWO, 8'hFF);
    wr(`IDX_PRIORITY_TWO, 8'hFF);
    rchk(`IDX_ENABLES_TWO, 8'h10);
    rchk(`IDX_PRIORITY_TWO, 8'h10);
    chk1(nvm_done_enable_out, 1'b1, "done enable");
    chk1(nvm_done_priority_out, 1'b1, "done priority");
  endtask

  task automatic t_refused_starts;
    wr(ULK, 8'h55);
    wr(ULK, 8'hAA);
    wr(CTL, 8'h02);
    #1 chk1(nvm_erase_out, 1'b0, "start without enable");
    rchk(CTL, 8'h08);
    wr(CTL, 8'h00);
    wr(ULK, 8'h55);
    wr(ULK, 8'hAA);
    wr(CTL, 8'h06);
    #1 chk1(nvm_erase_out, 1'b0, "enable and start together");
    rchk(CTL, 8'h0C);
    wr(CTL, 8'h04);
    wr(ULK, 8'h55);
    wr(ALO, 8'h00);
    wr(ULK, 8'hAA);
    wr(CTL, 8'h06);
    #1 chk1(nvm_erase_out, 1'b0, "broken unlock");
    rchk(CTL, 8'h0C);
    wr(CTL, 8'h04);
    wr(ULK, 8'hAA);
    wr(ULK, 8'h55);
    wr(CTL, 8'h06);
    #1 chk1(nvm_erase_out, 1'b0, "reversed unlock");
    wr(CTL, 8'h00);
  endtask

  task automatic t_eeprom_write;
    wr(FLG, 8'h00);
    wr(ALO, 8'h34);
    wr(`IDX_ADDR_HIGH, 8'hFF);
    wr(DAT, 8'hA5);
    start_wr(8'h04);
    chk1(nvm_erase_out, 1'b1, "erase phase");
    chk1(cpu_stall_out, 1'b0, "no stall for eeprom");
    chk({20'h0, nvm_target_out}, 22'h0, "target");
    chk(nvm_op_addr_out, 22'h334, "op address");
    chk({14'h0, nvm_op_data_out}, 22'hA5, "op data");
    // Writes while busy must be dropped
    wr(DAT, 8'h11);
    wr(CTL, 8'h00);
    wr(ALO, 8'h00);
    rchk(CTL, 8'h0E);
    wait_done;
    rchk(CTL, 8'h04);
    rchk(FLG, 8'h10);
    rchk(ALO, 8'h34);
    rchk(DAT, 8'hA5);
    wr(DAT, 8'h00);
    wr(CTL, 8'h05);
    rchk(DAT, 8'hA5);
    rchk(CTL, 8'h04);
    wr(FLG, 8'h00);
    rchk(FLG, 8'h00);
  endtask

  task automatic t_read_refused;
    wr(DAT, 8'h5A);
    wr(CTL, 8'h81);
    rchk(CTL, 8'h80);
    rchk(DAT, 8'h5A);
    wr(CTL, 8'h41);
    rchk(CTL, 8'h40);
    rchk(DAT, 8'h5A);
    wr(CTL, 8'h24);
    rchk(CTL, 8'h04);
    wr(CTL, 8'h00);
  endtask

  task automatic t_flash_ops;
    wr(`IDX_TBL_UPPER, 8'h01);
    wr(`IDX_TBL_HIGH, 8'h23);
    wr(`IDX_TBL_LOW, 8'h45);
    wr(`IDX_TBL_LATCH, 8'hC3);
    wr(FLG, 8'h00);
    start_wr(8'h94);
    chk1(nvm_erase_out, 1'b1, "row erase");
    chk({20'h0, nvm_target_out}, 22'h1, "flash target");
    chk(nvm_op_addr_out, 22'h012345, "erase address");
    rchk(`IDX_TBL_LATCH, 8'hC3);
    chk1(cpu_stall_out, 1'b1, "stall mid erase");
    wait_done;
    chk1(cpu_stall_out, 1'b0, "stall released");
    rchk(CTL, 8'h84);
    wr(FLG, 8'h00);
    start_wr(8'h84);
    chk1(nvm_program_out, 1'b1, "flash program");
    chk1(cpu_stall_out, 1'b1, "stall program");
    chk({14'h0, nvm_op_data_out}, 22'hC3, "latch data");
    wait_done;
    wr(FLG, 8'h00);
    start_wr(8'hC4);
    chk({20'h0, nvm_target_out}, 22'h2, "config target");
    chk1(cpu_stall_out, 1'b1, "stall config");
    wait_done;
    rchk(CTL, 8'hC4);
  endtask

  // Both warm reset sources abort a running write
  task automatic t_warm_reset;
    for (int i = 0; i < 2; i++) begin
      wr(FLG, 8'h00);
      start_wr(i == 1 ? 8'h44 : 8'h84);
      @(posedge sys_clk_in);
      master_clear_reset_in   <= (i == 0);
      watchdog_timer_reset_in <= (i == 1);
      @(posedge sys_clk_in);
      master_clear_reset_in   <= 1'b0;
      watchdog_timer_reset_in <= 1'b0;
      repeat (WCYC + 2) @(posedge sys_clk_in);
      rchk(CTL, i == 1 ? 8'h48 : 8'h88);
      chk1(nvm_done_flag_out, 1'b0, "no done after abort");
      chk1(cpu_stall_out, 1'b0, "stall dropped");
      wr(CTL, 8'h00);
    end
  endtask

  // Main sequence
  initial begin
    err_count               = 0;
    checked                 = 0;
    rst_b_in                = 1'b0;
    master_clear_reset_in   = 1'b0;
    watchdog_timer_reset_in = 1'b0;
    sfr_sel_in              = 4'h0;
    sfr_wr_in               = 1'b0;
    sfr_wdata_in            = 8'h00;
    repeat (4) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    t_reset_values;
    t_refused_starts;
    t_eeprom_write;
    t_read_refused;
    t_flash_ops;
    t_warm_reset;
    end_of_test;
  end
endmodule // testbench
